// file: bench/front_end_model.sv
module front_end_model
    import radio_dcf_pkg::*;
(
    // Clock
    input wire logic ref_clk_in,
    // Front-end pins
    input wire logic [NUM_PINS-1:0] pin_level_in,
    input wire logic [NUM_PINS-1:0] pin_sel_in,
    // Engaged lines
    output logic [NUM_PINS-1:0] engaged_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Unrouted pins arrive with pin_sel_in low, so they never engage
    always_ff @(posedge ref_clk_in) begin
        engaged_out <= pin_level_in & pin_sel_in;
    end
endmodule : front_end_model

// file: bench/test_radio_dcf_and_diag_irq.sv
module test_radio_dcf_and_diag_irq
    import radio_dcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic tx_en = 1'b0;
    logic rx_en = 1'b0;
    logic [7:0] diag = 8'h00;
    timer_cfg_t [NUM_TIMERS-1:0] cfg = '0;
    logic [NUM_PINS-1:0][FN_ID_W-1:0] pin_fn = '0;
    logic [15:0] sel_lo = 16'h0000;
    logic [15:0] sel_hi = 16'h0000;
    logic [NUM_TIMERS-1:0] timers;
    logic [NUM_PINS-1:0] pins;
    logic [NUM_PINS-1:0] pins_sel;
    logic [NUM_PINS-1:0] engaged;
    logic irq;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    radio_dcf_and_diag_irq radio_dcf_and_diag_irq_inst (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .tx_en_in(tx_en), .rx_en_in(rx_en), .link_diag_bit_in(diag),
        .timer_cfg_in(cfg), .pin_function_id_in(pin_fn),
        .diag_source_select_low_in(sel_lo),
        .diag_source_select_high_in(sel_hi),
        .radio_timer_out(timers), .pin_front_end_out(pins),
        .pin_front_end_sel_out(pins_sel), .radio_diag_interrupt_out(irq));

    front_end_model front_end_model_inst (
        .ref_clk_in(ref_clk_in), .pin_level_in(pins),
        .pin_sel_in(pins_sel), .engaged_out(engaged));

    initial begin
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // Hang guard: the whole run needs at most about 1600 cycles
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic step(int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : step

    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Free-running tick puts a delay of N between N-1 and N microseconds
    task automatic wait_bit(int idx, logic val, int lo, int hi, string what);
        int c;
        c = 0;
        while (timers[idx] !== val && c <= hi) begin
            step(1);
            c++;
        end
        n_tests++;
        if (c < lo || c > hi) begin
            n_mismatch++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, c);
        end
    endtask : wait_bit

    ////////////////////////////////////////////////////////////////////////
    task automatic test_routing();
        for (int i = 0; i < NUM_FE_OUTPUTS; i++) begin
            pin_fn[i] = FN_ID_FIRST + 6'(i);
        end
        pin_fn[5] = FN_ID_FIRST - 6'h01;
        pin_fn[6] = FN_ID_LAST + 6'h01;
        pin_fn[7] = 6'h00;
        cfg = '0;
        step(3);
        check("pin sel", 8'h1F, pins_sel);
        tx_en = 1'b1;
        step(3);
        check("timers on", 8'h3F, {2'b00, timers});
        check("pins on", 8'h1F, pins);
        check("engaged", 8'h1F, engaged);
        tx_en = 1'b0;
        step(3);
        check("pins off", 8'h00, pins);
    endtask : test_routing

    task automatic test_delay();
        cfg[1] = '{ref_is_rx: 1'b1, on_delay: 8'h02, off_delay: 8'h01};
        step(1);
        rx_en = 1'b1;
        wait_bit(1, 1'b1, 252, 501, "on delay");
        check("tx timers idle", 8'h00, {2'b00, timers & 6'h3D});
        rx_en = 1'b0;
        wait_bit(1, 1'b0, 2, 251, "off delay");
    endtask : test_delay

    task automatic run_pairs(logic [7:0] srcv);
        logic [31:0] all;
        logic [7:0] pb;
        for (int p = 0; p < NUM_PAIRS; p++) begin
            for (int w = 0; w < 4; w++) begin
                for (int b = 0; b < 8; b++) begin
                    pb = {1'b1, 1'b0, 2'(w), 1'b0, 3'(b)};
                    all = '0;
                    all[p*8 +: 8] = pb;
                    {sel_hi, sel_lo} = all;
                    step(3);
                    check("irq", {7'h00, (w < 2) ? diag[b] : srcv[b]},
                        {7'h00, irq});
                end
            end
        end
    endtask : run_pairs

    task automatic test_diag();
        for (int i = 0; i < NUM_TIMERS; i++) begin
            cfg[i] = '{ref_is_rx: ~i[0], on_delay: 8'h00, off_delay: 8'h00};
        end
        diag = 8'hA5;
        tx_en = 1'b1;
        step(3);
        run_pairs({1'b1, 1'b0, 6'b101010});
        tx_en = 1'b0;
        rx_en = 1'b1;
        step(3);
        run_pairs({1'b0, 1'b1, 6'b010101});
        // Disabled pair pointing at a high bit must stay silent
        {sel_hi, sel_lo} = 32'h0000_0000;
        step(3);
        check("irq disabled", 8'h00, {7'h00, irq});
        // Pair 0 low source, pair 3 high source combine
        {sel_hi, sel_lo} = 32'h8000_0081;
        step(3);
        check("irq combined", 8'h01, {7'h00, irq});
        diag = 8'h00;
        step(3);
        check("irq released", 8'h00, {7'h00, irq});
    endtask : test_diag

    ////////////////////////////////////////////////////////////////////////
    // Clock runs through reset so the block is live before any setup
    initial begin
        step(20);
        rst_b_in = 1'b1;
        step(2);
        check("idle timers", 8'h00, {2'b00, timers});
        check("idle irq", 8'h00, {7'h00, irq});
        // No bus here; settings arrive as whole static words
        test_routing();
        test_delay();
        test_diag();
        print_verdict();
    end
endmodule : test_radio_dcf_and_diag_irq

// file: core/front_end_timer_channel.sv
module front_end_timer_channel
    import radio_dcf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Timing
    input wire logic tick_us_in,
    input wire logic ref_in,
    input wire logic [DELAY_W-1:0] on_delay_in,
    input wire logic [DELAY_W-1:0] off_delay_in,
    // Output level
    output logic level_out
);

    chan_state_t state_reg;
    chan_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.ref_prev = ref_in;
        // Countdowns move only on microsecond ticks
        if (tick_us_in) begin
            if (state_reg.on_pend) begin
                if (state_reg.on_cnt <= 8'h01) begin
                    state_next.on_pend = 1'b0;
                    state_next.level = 1'b1;
                end else begin
                    state_next.on_cnt = state_reg.on_cnt - 8'h01;
                end
            end
            if (state_reg.off_pend) begin
                if (state_reg.off_cnt <= 8'h01) begin
                    state_next.off_pend = 1'b0;
                    state_next.level = 1'b0;
                end else begin
                    state_next.off_cnt = state_reg.off_cnt - 8'h01;
                end
            end
        end
        // Fresh edge restarts its own countdown
        if (ref_in && !state_reg.ref_prev) begin
            state_next.on_cnt = on_delay_in;
            state_next.on_pend = (on_delay_in != 8'h00);
            if (on_delay_in == 8'h00) begin
                state_next.level = 1'b1;
            end
        end
        if (!ref_in && state_reg.ref_prev) begin
            state_next.off_cnt = off_delay_in;
            state_next.off_pend = (off_delay_in != 8'h00);
            if (off_delay_in == 8'h00) begin
                state_next.level = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= CHAN_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_out = state_reg.level;

    a_rise_zero_on: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (ref_in && !state_reg.ref_prev && on_delay_in == 8'h00)
        |=> level_out)
        else $error("Zero on-delay did not assert at the edge");

    a_fall_zero_off: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (!ref_in && state_reg.ref_prev && off_delay_in == 8'h00)
        |=> !level_out)
        else $error("Zero off-delay did not deassert at the edge");

endmodule : front_end_timer_channel

// file: core/radio_dcf_and_diag_irq.sv
// Notes on behaviour
// - Five front-end outputs, each edge placed with one microsecond steps.
// - Each front-end output reaches any pin through function ids 55 to 59.
// - Output timing is an offset from transmit or receive enable edges.
// - Diagnostic interrupt sources come from link diag and radio signals.
// - Four identical word/bit selector pairs, each choosing one source.
// - Words 0-1 pick diag bits; words 2-3 pick enables and timers.
// - Radio timers 21 to 26 are the timed outputs, visible as sources.
module radio_dcf_and_diag_irq
    import radio_dcf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Link-layer signals
    input wire logic tx_en_in,
    input wire logic rx_en_in,
    input wire logic [7:0] link_diag_bit_in,
    // Timer configuration
    input wire timer_cfg_t [NUM_TIMERS-1:0] timer_cfg_in,
    // Pin routing
    input wire logic [NUM_PINS-1:0][FN_ID_W-1:0] pin_function_id_in,
    // Diagnostic interrupt selection
    input wire logic [15:0] diag_source_select_low_in,
    input wire logic [15:0] diag_source_select_high_in,
    // Outputs
    output logic [NUM_TIMERS-1:0] radio_timer_out,
    output logic [NUM_PINS-1:0] pin_front_end_out,
    output logic [NUM_PINS-1:0] pin_front_end_sel_out,
    output logic radio_diag_interrupt_out
);

    typedef struct packed {
        logic [7:0] prescale;
        logic tick;
        logic [NUM_PINS-1:0] pin_level;
        logic [NUM_PINS-1:0] pin_sel;
        logic irq;
    } top_state_t;

    localparam top_state_t TOP_RESET = '{
        prescale: PRESCALE_RESET,
        tick: 1'b0,
        pin_level: '0,
        pin_sel: '0,
        irq: 1'b0
    };

    top_state_t state_reg;
    top_state_t state_next;
    logic [NUM_TIMERS-1:0] timer_level;
    logic [NUM_PAIRS-1:0] pair_hit;
    logic [31:0] select_all;

    assign select_all = {diag_source_select_high_in,
                         diag_source_select_low_in};

    ////////////////////////////////////////////////////////////////////////
    // Timed channels; the sixth drives no pin, only radio_timer_out and the diag sources
    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
        front_end_timer_channel front_end_timer_channel_inst (
            .ref_clk_in(ref_clk_in),
            .rst_b_in(rst_b_in),
            .tick_us_in(state_reg.tick),
            .ref_in(timer_cfg_in[t].ref_is_rx ? rx_en_in : tx_en_in),
            .on_delay_in(timer_cfg_in[t].on_delay),
            .off_delay_in(timer_cfg_in[t].off_delay),
            .level_out(timer_level[t])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Source decode for the four selector pairs
    always_comb begin
        logic [2:0] bsel;
        logic [1:0] wsel;
        logic en;
        bsel = 3'h0;
        wsel = 2'h0;
        en = 1'b0;
        pair_hit = '0;
        for (int p = 0; p < NUM_PAIRS; p++) begin
            bsel = select_all[p*PAIR_BITS+BSEL_LSB +: 3];
            wsel = select_all[p*PAIR_BITS+WSEL_LSB +: 2];
            en = select_all[p*PAIR_BITS+PAIR_EN_BIT];
            if (!en) begin
                pair_hit[p] = 1'b0;
            end else if (!wsel[1]) begin
                pair_hit[p] = link_diag_bit_in[bsel];
            end else if (bsel == BSEL_TX) begin
                pair_hit[p] = tx_en_in;
            end else if (bsel == BSEL_RX) begin
                pair_hit[p] = rx_en_in;
            end else begin
                pair_hit[p] = timer_level[bsel];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_next = state_reg;
        // Free-running tick; phase is arbitrary, so resolution is 1 us
        state_next.tick = (state_reg.prescale == US_LAST);
        if (state_reg.prescale == US_LAST) begin
            state_next.prescale = 8'h00;
        end else begin
            state_next.prescale = state_reg.prescale + 8'h01;
        end
        for (int g = 0; g < NUM_PINS; g++) begin
            state_next.pin_level[g] = 1'b0;
            state_next.pin_sel[g] = 1'b0;
            for (int t = 0; t < NUM_FE_OUTPUTS; t++) begin
                if (pin_function_id_in[g] == FN_ID_FIRST + 6'(t)) begin
                    state_next.pin_level[g] = timer_level[t];
                    state_next.pin_sel[g] = 1'b1;
                end
            end
        end
        // Registered so a glitch in the selector mux never reaches the CPU
        state_next.irq = |pair_hit;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= TOP_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign radio_timer_out = timer_level;
    assign pin_front_end_out = state_reg.pin_level;
    assign pin_front_end_sel_out = state_reg.pin_sel;
    assign radio_diag_interrupt_out = state_reg.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_tick_gap;
        !state_reg.tick [*8];
    endsequence

    a_tick_spacing: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        state_reg.tick |=> s_tick_gap ##242 state_reg.tick)
        else $error("Microsecond tick spacing is not 250 cycles");

    a_pin_route_first: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (pin_function_id_in[0] == FN_ID_FIRST)
        |=> pin_front_end_out[0] == $past(timer_level[0]))
        else $error("Pin 0 does not follow the first timed output");

    a_pin_route_last: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (pin_function_id_in[4] == FN_ID_LAST)
        |=> pin_front_end_out[4] == $past(timer_level[4])
            && pin_front_end_sel_out[4])
        else $error("Pin 4 does not follow the fifth timed output");

    a_irq_any_high: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (|pair_hit) |=> radio_diag_interrupt_out)
        else $error("Interrupt low while a selected source is high");

    a_irq_none_low: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        !(|pair_hit) |=> !radio_diag_interrupt_out)
        else $error("Interrupt high with no selected source");

    a_sel_tx_enable: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (select_all[PAIR_EN_BIT] && select_all[WSEL_LSB+1]
         && select_all[2:0] == BSEL_TX)
        |-> pair_hit[0] == tx_en_in)
        else $error("Pair 0 does not pick the transmit enable");

    a_sel_diag_bit: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (select_all[PAIR_BITS+PAIR_EN_BIT] && !select_all[PAIR_BITS+5])
        |-> pair_hit[1] == link_diag_bit_in[select_all[PAIR_BITS +: 3]])
        else $error("Pair 1 does not pick the link diag bit");

    a_sel_timer_src: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (select_all[3*PAIR_BITS+PAIR_EN_BIT] && select_all[3*PAIR_BITS+5]
         && select_all[3*PAIR_BITS +: 3] == 3'h5)
        |-> pair_hit[3] == timer_level[5])
        else $error("Pair 3 does not pick the last radio timer");

    a_sel_rx_enable: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (select_all[2*PAIR_BITS+PAIR_EN_BIT] && select_all[2*PAIR_BITS+5]
         && select_all[2*PAIR_BITS +: 3] == BSEL_RX)
        |-> pair_hit[2] == rx_en_in)
        else $error("Pair 2 does not pick the receive enable");

    a_sel_word_one: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (select_all[PAIR_EN_BIT] && select_all[WSEL_LSB +: 2] == 2'h1)
        |-> pair_hit[0] == link_diag_bit_in[select_all[2:0]])
        else $error("Pair 0 word one does not pick the link diag bit");

    a_pair_off_silent: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        !select_all[PAIR_BITS+PAIR_EN_BIT] |-> !pair_hit[1])
        else $error("Disabled pair 1 still feeds the interrupt");

    a_pin_unrouted: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (pin_function_id_in[6] < FN_ID_FIRST
         || pin_function_id_in[6] > FN_ID_LAST)
        |=> !pin_front_end_sel_out[6] && !pin_front_end_out[6])
        else $error("Pin 6 driven without a front-end function id");

    a_pin_sel_first: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (pin_function_id_in[0] == FN_ID_FIRST) |=> pin_front_end_sel_out[0])
        else $error("Pin 0 not marked as a front-end pin");

    a_prescale_wrap: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        (state_reg.prescale == US_LAST)
        |=> state_reg.prescale == 8'h00 && state_reg.tick)
        else $error("Microsecond prescaler did not wrap with a tick");

endmodule : radio_dcf_and_diag_irq

// file: core/radio_dcf_pkg.sv
package radio_dcf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Counts and sizes
    localparam int NUM_TIMERS = 6;
    localparam int NUM_FE_OUTPUTS = 5;
    localparam int NUM_PINS = 8;
    localparam int NUM_PAIRS = 4;
    localparam int DELAY_W = 8;
    localparam int FN_ID_W = 6;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TIME_RES_US = 1;
    localparam int US_CYCLES = (TIME_RES_US * 1000000) / CLK_PERIOD_PS;
    localparam logic [7:0] US_LAST = 8'(US_CYCLES - 1);
    localparam logic [7:0] PRESCALE_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Pin function identifiers of the five front-end outputs
    localparam logic [FN_ID_W-1:0] FN_ID_FIRST = 6'h37;
    localparam logic [FN_ID_W-1:0] FN_ID_LAST = 6'h3B;

    ////////////////////////////////////////////////////////////////////////
    // Selector pair layout inside each byte of a selection register
    localparam int PAIR_BITS = 8;
    localparam int BSEL_LSB = 0;
    localparam int WSEL_LSB = 4;
    localparam int PAIR_EN_BIT = 7;
    localparam logic [2:0] BSEL_TX = 3'h7;
    localparam logic [2:0] BSEL_RX = 3'h6;

    ////////////////////////////////////////////////////////////////////////
    // Carriers and state
    typedef struct packed {
        logic ref_is_rx;
        logic [DELAY_W-1:0] on_delay;
        logic [DELAY_W-1:0] off_delay;
    } timer_cfg_t;

    typedef struct packed {
        logic ref_prev;
        logic on_pend;
        logic [DELAY_W-1:0] on_cnt;
        logic off_pend;
        logic [DELAY_W-1:0] off_cnt;
        logic level;
    } chan_state_t;

    localparam chan_state_t CHAN_RESET = '0;

    typedef enum logic [1:0] {
        REF_LOW = 2'h1,
        REF_HIGH = 2'h2
    } ref_phase_t;

endpackage : radio_dcf_pkg
